// ### logic/twi_status_timing.sv
// Status flags, bus tracking, master SCL timing and AXI4-Lite registers.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module twi_status_timing
  import twi_status_pkg::*;
#(
  parameter int PERIOD_W = 12
)(
  input  wire logic        CLOCK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic        AWVALID_IN,
  output logic             AWREADY_OUT,
  input  wire logic [7:0]  AWADDR_IN,
  input  wire logic        WVALID_IN,
  output logic             WREADY_OUT,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic [3:0]  WSTRB_IN,
  output logic             BVALID_OUT,
  input  wire logic        BREADY_IN,
  output logic [1:0]       BRESP_OUT,
  input  wire logic        ARVALID_IN,
  output logic             ARREADY_OUT,
  input  wire logic [7:0]  ARADDR_IN,
  output logic             RVALID_OUT,
  input  wire logic        RREADY_IN,
  output logic [31:0]      RDATA_OUT,
  output logic [1:0]       RRESP_OUT,
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE_N_OUT,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N_OUT,
  input  wire logic        SDA_LOW_IN,
  input  wire addr_event_s ADDR_EVENT_IN,
  input  wire logic        LOST_ARBITRATION_IN,
  input  wire logic [7:0]  PACKET_CHECK_BYTE_IN,
  output logic [7:0]       BYTE_BUFFER_OUT,
  output logic             BYTE_BUFFER_WRITE_OUT
);

  if (PERIOD_W != 12)
    $error("PERIOD_W must be 12");

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_LOW, ST_RISE, ST_HIGH} scl_state_e;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [15:0] phase_len(input logic fast, input logic duty,
                                            input logic high, input logic [11:0] n);
    logic [15:0] w;
    w = {4'h0, n};
    if (!fast)
      return w;
    if (!duty)
      return high ? w : (w << 1);
    return high ? (w * 16'h0009) : (w << 4);
  endfunction : phase_len

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic        interface_on, packet_check_enable, address_resolution_enable;
  logic        host_role_select, broadcast_call_enable;
  logic        start_req, stop_req;
  logic [15:0] scl_period_control;
  logic [5:0]  rise_limit_count;
  logic        addr_flag, start_generated_flag, one_read;
  logic        second_own_match, host_header_seen, default_device_header_seen;
  logic        broadcast_call_seen, send_direction, bus_busy, controller_role;
  logic [2:0]  scl_sync, sda_sync;
  logic        scl_f, sda_f, scl_p, sda_p;
  logic        start_seen, stop_seen;
  scl_state_e  state;
  logic [15:0] cnt;
  logic [5:0]  rise_cnt;
  logic        sda_stop_drive;
  logic        aw_full, w_full;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go, rd_go;
  logic        rd_one, rd_two, wr_buf;
  logic [15:0] low_len, high_len, status_one, status_two;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign AWREADY_OUT = !aw_full && !BVALID_OUT;
  assign WREADY_OUT  = !w_full && !BVALID_OUT;
  assign ARREADY_OUT = !RVALID_OUT;
  assign wr_go  = aw_full && w_full && !BVALID_OUT;
  assign rd_go  = ARVALID_IN && ARREADY_OUT;
  assign rd_one = rd_go && ARADDR_IN == OFS_STATUS_ONE;
  assign rd_two = rd_go && ARADDR_IN == OFS_STATUS_TWO;
  assign wr_buf = wr_go && aw_addr == OFS_BYTE_BUFFER && w_strb[0];

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
    begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (AWVALID_IN && AWREADY_OUT)
      begin
        aw_full <= 1'b1;
        aw_addr <= AWADDR_IN;
      end
      else if (wr_go)
        aw_full <= 1'b0;
      if (WVALID_IN && WREADY_OUT)
      begin
        w_full <= 1'b1;
        w_data <= WDATA_IN;
        w_strb <= WSTRB_IN;
      end
      else if (wr_go)
        w_full <= 1'b0;
    end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
    begin
      BVALID_OUT <= 1'b0;
      BRESP_OUT  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      BVALID_OUT <= 1'b1;
      unique case (aw_addr)
        OFS_CONTROL, OFS_BYTE_BUFFER, OFS_STATUS_ONE, OFS_STATUS_TWO,
        OFS_SCL_PERIOD, OFS_RISE_LIMIT: BRESP_OUT <= RESP_OKAY;
        default:                        BRESP_OUT <= RESP_SLVERR;
      endcase
    end
    else if (BREADY_IN)
      BVALID_OUT <= 1'b0;

  assign status_one = {14'h0000, addr_flag, start_generated_flag};
  assign status_two = {packet_check_enable ? PACKET_CHECK_BYTE_IN : 8'h00,
                       second_own_match, host_header_seen, default_device_header_seen,
                       broadcast_call_seen, 1'b0, send_direction, bus_busy, controller_role};

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
    begin
      RVALID_OUT <= 1'b0;
      RDATA_OUT  <= 32'h0000_0000;
      RRESP_OUT  <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      RVALID_OUT <= 1'b1;
      RRESP_OUT  <= RESP_OKAY;
      unique case (ARADDR_IN)
        OFS_CONTROL:     RDATA_OUT <= {22'h000000, stop_req, start_req, 3'h0,
                                       broadcast_call_enable, host_role_select,
                                       address_resolution_enable, packet_check_enable,
                                       interface_on};
        OFS_BYTE_BUFFER: RDATA_OUT <= {24'h000000, BYTE_BUFFER_OUT};
        OFS_STATUS_ONE:  RDATA_OUT <= {16'h0000, status_one};
        OFS_STATUS_TWO:  RDATA_OUT <= {16'h0000, status_two};
        OFS_SCL_PERIOD:  RDATA_OUT <= {16'h0000, scl_period_control};
        OFS_RISE_LIMIT:  RDATA_OUT <= {26'h0000000, rise_limit_count};
        default:
        begin
          RDATA_OUT <= 32'h0000_0000;
          RRESP_OUT <= RESP_SLVERR;
        end
      endcase
    end
    else if (RREADY_IN)
      RVALID_OUT <= 1'b0;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
    begin
      interface_on              <= 1'b0;
      packet_check_enable       <= 1'b0;
      address_resolution_enable <= 1'b0;
      host_role_select          <= 1'b0;
      broadcast_call_enable     <= 1'b0;
      scl_period_control        <= RST_SCL_PERIOD;
      rise_limit_count          <= RST_RISE_LIMIT;
      BYTE_BUFFER_OUT           <= 8'h00;
      BYTE_BUFFER_WRITE_OUT     <= 1'b0;
    end
    else
    begin
      BYTE_BUFFER_WRITE_OUT <= wr_buf;
      if (wr_buf)
        BYTE_BUFFER_OUT <= w_data[7:0];
      if (wr_go && aw_addr == OFS_CONTROL && w_strb[0])
      begin
        interface_on              <= w_data[CTL_ON];
        packet_check_enable       <= w_data[CTL_PCE];
        address_resolution_enable <= w_data[CTL_ARE];
        host_role_select          <= w_data[CTL_HOST];
        broadcast_call_enable     <= w_data[CTL_BCAST];
      end
      if (wr_go && aw_addr == OFS_SCL_PERIOD)
      begin
        if (w_strb[0])
          scl_period_control[7:0] <= w_data[7:0];
        if (w_strb[1])
          scl_period_control[15:8] <= {w_data[15:14], 2'h0, w_data[11:8]};
      end
      if (wr_go && aw_addr == OFS_RISE_LIMIT && w_strb[0])
        rise_limit_count <= w_data[5:0];
    end

  // Start and stop requests wait until the clock machine takes them.
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
    begin
      start_req <= 1'b0;
      stop_req  <= 1'b0;
    end
    else if (!interface_on)
    begin
      start_req <= 1'b0;
      stop_req  <= 1'b0;
    end
    else
    begin
      if (wr_go && aw_addr == OFS_CONTROL && w_strb[1] && w_data[CTL_START])
        start_req <= 1'b1;
      else if (state == ST_START)
        start_req <= 1'b0;
      if (wr_go && aw_addr == OFS_CONTROL && w_strb[1] && w_data[CTL_STOP])
        stop_req <= 1'b1;
      else if (state == ST_HIGH && sda_stop_drive && cnt + 16'h0001 >= high_len)
        stop_req <= 1'b0;
    end

  // ----------------------------------------------------------------
  // Line sampling and bus conditions
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
    begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      scl_p    <= 1'b1;
      sda_p    <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[1:0], SCL_IN};
      sda_sync <= {sda_sync[1:0], SDA_IN};
      if (scl_sync[1] == scl_sync[2])
        scl_f <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2])
        sda_f <= sda_sync[2];
      scl_p <= scl_f;
      sda_p <= sda_f;
    end

  assign start_seen = scl_f && scl_p && sda_p && !sda_f;
  assign stop_seen  = scl_f && scl_p && !sda_p && sda_f;

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
      bus_busy <= 1'b0;
    else if (!scl_f || !sda_f)
      bus_busy <= 1'b1;
    else if (stop_seen)
      bus_busy <= 1'b0;

  // ----------------------------------------------------------------
  // Address phase flags
  // ----------------------------------------------------------------
  logic addr_hit;
  always_comb
  begin
    addr_hit = 1'b0;
    if (ADDR_EVENT_IN.done && ADDR_EVENT_IN.ack)
      unique case (ADDR_EVENT_IN.kind)
        KIND_FIRST_OWN, KIND_SECOND_OWN, KIND_ALERT_HDR: addr_hit = 1'b1;
        KIND_BROADCAST:   addr_hit = broadcast_call_enable;
        KIND_DEFAULT_DEV: addr_hit = address_resolution_enable;
        KIND_HOST_HDR:    addr_hit = address_resolution_enable && host_role_select;
        KIND_MASTER_7BIT, KIND_MASTER_10BIT_TAIL: addr_hit = 1'b1;
        KIND_MASTER_10BIT_HEAD: addr_hit = 1'b0;
        default:          addr_hit = 1'b0;
      endcase
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
      one_read <= 1'b0;
    else if (rd_one)
      one_read <= 1'b1;
    else if (rd_two || wr_buf)
      one_read <= 1'b0;

  // A hit in the clearing cycle wins over the clear.
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
      addr_flag <= 1'b0;
    else if (!interface_on)
      addr_flag <= 1'b0;
    else if (addr_hit && interface_on)
      addr_flag <= 1'b1;
    else if (rd_two && one_read)
      addr_flag <= 1'b0;

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
    begin
      second_own_match           <= 1'b0;
      host_header_seen           <= 1'b0;
      default_device_header_seen <= 1'b0;
      broadcast_call_seen        <= 1'b0;
    end
    else if (!interface_on || stop_seen || start_seen)
    begin
      second_own_match           <= 1'b0;
      host_header_seen           <= 1'b0;
      default_device_header_seen <= 1'b0;
      broadcast_call_seen        <= 1'b0;
    end
    else if (addr_hit)
    begin
      second_own_match           <= ADDR_EVENT_IN.kind == KIND_SECOND_OWN;
      host_header_seen           <= ADDR_EVENT_IN.kind == KIND_HOST_HDR;
      default_device_header_seen <= ADDR_EVENT_IN.kind == KIND_DEFAULT_DEV;
      broadcast_call_seen        <= ADDR_EVENT_IN.kind == KIND_BROADCAST;
    end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
      send_direction <= 1'b0;
    else if (!interface_on || stop_seen || start_seen || LOST_ARBITRATION_IN)
      send_direction <= 1'b0;
    else if (addr_hit)
      send_direction <= ADDR_EVENT_IN.sends;

  // ----------------------------------------------------------------
  // Start flag and role
  // ----------------------------------------------------------------
  logic start_made;
  assign start_made = state == ST_START && cnt + 16'h0001 >= high_len;

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
      start_generated_flag <= 1'b0;
    else if (!interface_on)
      start_generated_flag <= 1'b0;
    else if (start_made)
      start_generated_flag <= 1'b1;
    else if (wr_buf && one_read)
      start_generated_flag <= 1'b0;

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
      controller_role <= 1'b0;
    else if (!interface_on)
      controller_role <= 1'b0;
    else if (start_made)
      controller_role <= 1'b1;
    else if (stop_seen || LOST_ARBITRATION_IN)
      controller_role <= 1'b0;

  // ----------------------------------------------------------------
  // Master SCL generation
  // ----------------------------------------------------------------
  assign low_len  = phase_len(scl_period_control[CCR_FAST], scl_period_control[CCR_DUTY],
                              1'b0, scl_period_control[11:0]);
  assign high_len = phase_len(scl_period_control[CCR_FAST], scl_period_control[CCR_DUTY],
                              1'b1, scl_period_control[11:0]);

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
    if (!RESETN_IN)
    begin
      state          <= ST_IDLE;
      cnt            <= 16'h0000;
      rise_cnt       <= 6'h00;
      sda_stop_drive <= 1'b0;
    end
    else if (!interface_on || LOST_ARBITRATION_IN)
    begin
      state          <= ST_IDLE;
      cnt            <= 16'h0000;
      sda_stop_drive <= 1'b0;
    end
    else
      unique case (state)
        ST_IDLE:
        begin
          cnt <= 16'h0000;
          if (start_req && !bus_busy)
            state <= ST_START;
        end
        ST_START:
          if (cnt + 16'h0001 >= high_len)
          begin
            cnt   <= 16'h0000;
            state <= ST_LOW;
          end
          else
            cnt <= cnt + 16'h0001;
        ST_LOW:
          if (cnt + 16'h0001 >= low_len)
          begin
            cnt            <= 16'h0000;
            rise_cnt       <= 6'h00;
            sda_stop_drive <= stop_req;
            state          <= ST_RISE;
          end
          else
            cnt <= cnt + 16'h0001;
        ST_RISE:
          if (scl_f || rise_cnt + 6'h01 >= rise_limit_count)
            state <= ST_HIGH;
          else
            rise_cnt <= rise_cnt + 6'h01;
        ST_HIGH:
          if (cnt + 16'h0001 >= high_len)
          begin
            cnt            <= 16'h0000;
            sda_stop_drive <= 1'b0;
            state          <= sda_stop_drive ? ST_IDLE : ST_LOW;
          end
          else
            cnt <= cnt + 16'h0001;
      endcase

  assign SCL_OUT      = 1'b0;
  assign SDA_OUT      = 1'b0;
  assign SCL_OE_N_OUT = !(state == ST_LOW);
  assign SDA_OE_N_OUT = !(state == ST_START || sda_stop_drive ||
                          (controller_role && SDA_LOW_IN && state != ST_IDLE));

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ADDR_CLEAR: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN)
    (rd_two && one_read && !addr_hit) |=> !addr_flag)
    else $error("address flag not cleared by status read pair");
  AST_ADDR_NACK: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN)
    (!addr_flag && ADDR_EVENT_IN.done && !ADDR_EVENT_IN.ack) |=> !addr_flag)
    else $error("address flag set after not-acknowledge");
  AST_ADDR_SET: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN)
    (interface_on && ADDR_EVENT_IN.done && ADDR_EVENT_IN.ack &&
     ADDR_EVENT_IN.kind == KIND_FIRST_OWN) |=> addr_flag && !second_own_match)
    else $error("first own match not flagged");
  AST_ROLE_WITH_START: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN)
    $rose(start_generated_flag) |-> controller_role)
    else $error("role not set with start flag");
  AST_DISABLE: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN)
    !interface_on |=> !addr_flag && !start_generated_flag && !controller_role)
    else $error("flags survive disable");
  AST_BUSY: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN)
    $fell(sda_f) |-> ##1 bus_busy [*2])
    else $error("bus busy not raised on low line");
  AST_DIR_CLEAR: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN)
    (stop_seen || start_seen) |=> !send_direction && !broadcast_call_seen)
    else $error("slave flags survive stop or start");
  AST_PEC_READ: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN)
    rd_two |=> RDATA_OUT[15:8] ==
      ($past(packet_check_enable) ? $past(PACKET_CHECK_BYTE_IN) : 8'h00))
    else $error("packet check byte misreported");
  AST_LOW_LEN: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN)
    (state == ST_LOW && $past(state) != ST_LOW && interface_on && !LOST_ARBITRATION_IN &&
     low_len == 16'h0004) |-> (state == ST_LOW) [*4])
    else $error("low phase length wrong");
  AST_RISE_LIMIT: assert property (@(posedge CLOCK_IN) disable iff (!RESETN_IN)
    state == ST_RISE |-> rise_cnt < rise_limit_count || rise_limit_count == 6'h00)
    else $error("rise wait exceeded limit");

endmodule : twi_status_timing
`default_nettype wire

// ### logic/twi_status_pkg.sv
// Constants, field layouts and carrier types of the two-wire status and clock block.
// Contract
// - status one then two read clears address
// - slave match or enabled header sets address
// - master sets address after final address acknowledge
// - not-acknowledged address phase leaves address clear
// - start flag set; cleared by read-then-buffer-write
// - second read does not clear address if newly set
// - upper status two byte shows packet check
// - second own match bit, cleared stop/start/disable
// - host and default headers gated by enables
// - broadcast flag only when broadcast enabled
// - direction from read/write bit, cleared on ends
// - bus busy on low line, cleared by stop
// - role set with start flag, cleared on ends
// - speed select bit picks standard or fast
// - standard speed high and low equal count
// - fast speed multiplies count by 1,2,9,16
// - rise limit bounds the clock feedback loop
package twi_status_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL     = 8'h00;
  localparam logic [7:0] OFS_BYTE_BUFFER = 8'h10;
  localparam logic [7:0] OFS_STATUS_ONE  = 8'h14;
  localparam logic [7:0] OFS_STATUS_TWO  = 8'h18;
  localparam logic [7:0] OFS_SCL_PERIOD  = 8'h1C;
  localparam logic [7:0] OFS_RISE_LIMIT  = 8'h20;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_SCL_PERIOD = 16'h0000;
  localparam logic [5:0]  RST_RISE_LIMIT = 6'h02;
  localparam int CTL_ON       = 0;
  localparam int CTL_PCE      = 1;
  localparam int CTL_ARE      = 2;
  localparam int CTL_HOST     = 3;
  localparam int CTL_BCAST    = 4;
  localparam int CTL_START    = 8;
  localparam int CTL_STOP     = 9;
  localparam int CCR_FAST     = 15;
  localparam int CCR_DUTY     = 14;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    KIND_FIRST_OWN, KIND_SECOND_OWN, KIND_BROADCAST, KIND_DEFAULT_DEV,
    KIND_HOST_HDR, KIND_ALERT_HDR, KIND_MASTER_7BIT, KIND_MASTER_10BIT_HEAD,
    KIND_MASTER_10BIT_TAIL
  } addr_kind_e;

  typedef struct packed {
    logic       done;
    logic       ack;
    logic       sends;
    addr_kind_e kind;
  } addr_event_s;

endpackage : twi_status_pkg

// ### testbench/twi_bus_model.sv
// Pulled-up two-wire bus with a slave that stretches the clock line.
`timescale 1ns/1ps
`default_nettype none
module twi_bus_model
(
  input  wire logic       CLOCK_IN,
  input  wire logic       SCL_OE_N_IN,
  input  wire logic       SDA_OE_N_IN,
  input  wire logic [3:0] STRETCH_IN,
  output logic            SCL_OUT,
  output logic            SDA_OUT
);
  logic [3:0] hold = 4'h0;
  always_ff @(posedge CLOCK_IN)
  begin
    if (!SCL_OE_N_IN)
      hold <= STRETCH_IN;
    else if (hold != 4'h0)
      hold <= hold - 4'h1;
  end
  assign SCL_OUT = SCL_OE_N_IN && (hold == 4'h0);
  assign SDA_OUT = SDA_OE_N_IN;
endmodule : twi_bus_model
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the status flags and clock timing block.
`timescale 1ns/1ps
`default_nettype none
module tb import twi_status_pkg::*;;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] e;} row_s;
  row_s        rows [4] = '{'{8'h1C, 32'h0000F0FF, 32'h0000C0FF, RESP_OKAY},
                            '{8'h20, 32'h000000FF, 32'h0000003F, RESP_OKAY},
                            '{8'h18, 32'h0000FFFF, 32'h00000000, RESP_OKAY},
                            '{8'h3C, 32'h0000FFFF, 32'h00000000, RESP_SLVERR}};
  logic [15:0] ccr [3] = '{16'h0004, 16'h8004, 16'hC001};
  logic [31:0] low [3] = '{32'h4, 32'h8, 32'h10};
  addr_kind_e  hk [3] = '{KIND_BROADCAST, KIND_HOST_HDR, KIND_DEFAULT_DEV};
  logic [31:0] hm [3] = '{32'h10, 32'h40, 32'h20};
  logic        clk, rst_n, awv, wvl, brd, arv, rrd, sda_low, lost;
  logic [7:0]  awa, ara, pcb;
  logic [31:0] wdt, rdv, n;
  logic [1:0]  rsp;
  logic [3:0]  str;
  addr_event_s ev;
  wire logic   awr, wrd, bvl, arr, rvl, scl_oe, sda_oe, scl, sda, bbw;
  wire logic [7:0]  bbo;
  int          nbw = 0;
  wire logic [1:0]  brs, rrs;
  wire logic [31:0] rdt;
  int          n_fail = 0;
  int          n_checks = 0;
  twi_status_timing twi_status_timing_inst (.CLOCK_IN(clk), .RESETN_IN(rst_n),
    .AWVALID_IN(awv), .AWREADY_OUT(awr), .AWADDR_IN(awa), .WVALID_IN(wvl), .WREADY_OUT(wrd),
    .WDATA_IN(wdt), .WSTRB_IN(4'hF), .BVALID_OUT(bvl), .BREADY_IN(brd), .BRESP_OUT(brs),
    .ARVALID_IN(arv), .ARREADY_OUT(arr), .ARADDR_IN(ara), .RVALID_OUT(rvl), .RREADY_IN(rrd),
    .RDATA_OUT(rdt), .RRESP_OUT(rrs), .SCL_IN(scl), .SCL_OUT(), .SCL_OE_N_OUT(scl_oe),
    .SDA_IN(sda), .SDA_OUT(), .SDA_OE_N_OUT(sda_oe), .SDA_LOW_IN(sda_low), .ADDR_EVENT_IN(ev),
    .LOST_ARBITRATION_IN(lost), .PACKET_CHECK_BYTE_IN(pcb), .BYTE_BUFFER_OUT(bbo),
    .BYTE_BUFFER_WRITE_OUT(bbw));
  always @(posedge clk)
    if (bbw === 1'b1)
      nbw <= nbw + 1;
  twi_bus_model twi_bus_model_inst (.CLOCK_IN(clk), .SCL_OE_N_IN(scl_oe),
    .SDA_OE_N_IN(sda_oe), .STRETCH_IN(str), .SCL_OUT(scl), .SDA_OUT(sda));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x)
    begin
      $display("MISMATCH %0t got %h expected %h", $time, g, x);
      n_fail++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wdt <= d;
    awv <= 1'b1;
    wvl <= 1'b1;
    brd <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wvl <= 1'b0;
    end
    while (bvl !== 1'b1);
    rsp = brs;
    brd <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end
    while (rvl !== 1'b1);
    rdv = rdt;
    rrd <= 1'b0;
  endtask : rd
  task automatic evt(input addr_kind_e k, input logic ack);
    @(posedge clk);
    ev <= '{1'b1, ack, 1'b1, k};
    @(posedge clk);
    ev <= '0;
  endtask : evt
  task automatic reset_dut;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
  endtask : reset_dut
  task automatic print_verdict;
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #2000000;
    n_fail++;
    print_verdict;
  end
  initial
  begin
    {rst_n, awv, wvl, brd, arv, rrd, sda_low, lost, awa, ara, wdt, ev} = '0;
    pcb = 8'hA5;
    str = 4'h3;
    reset_dut;
    rd(OFS_SCL_PERIOD);
    chk(rdv, {16'h0, RST_SCL_PERIOD});
    rd(OFS_RISE_LIMIT);
    chk(rdv, {26'h0, RST_RISE_LIMIT});
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      chk({30'h0, rsp}, {30'h0, rows[i].e});
      rd(rows[i].a);
      chk(rdv, rows[i].r);
    end
    foreach (ccr[i])
    begin
      reset_dut;
      wr(OFS_SCL_PERIOD, {16'h0, ccr[i]});
      wr(OFS_RISE_LIMIT, 32'h9);
      wr(OFS_CONTROL, 32'h1);
      wr(OFS_CONTROL, 32'h101);
      n = 0;
      while (scl_oe !== 1'b0) @(posedge clk);
      while (scl_oe === 1'b0)
      begin
        @(posedge clk);
        n++;
      end
      chk(n, low[i]);
    end
    rd(OFS_STATUS_ONE);
    chk(rdv & 32'h1, 32'h1);
    rd(OFS_STATUS_TWO);
    chk(rdv & 32'h3, 32'h3);
    rd(OFS_STATUS_ONE);
    wr(OFS_BYTE_BUFFER, 32'h5A);
    rd(OFS_STATUS_ONE);
    chk(rdv & 32'h1, 32'h0);
    chk(nbw, 32'h1);
    chk({24'h0, bbo}, 32'h5A);
    wr(OFS_CONTROL, 32'h201);
    repeat (100) @(posedge clk);
    rd(OFS_STATUS_TWO);
    chk(rdv & 32'h3, 32'h0);
    wr(OFS_CONTROL, 32'h101);
    repeat (20) @(posedge clk);
    rd(OFS_STATUS_TWO);
    chk(rdv & 32'h3, 32'h3);
    @(posedge clk) lost <= 1'b1;
    @(posedge clk) lost <= 1'b0;
    rd(OFS_STATUS_TWO);
    chk(rdv & 32'h1, 32'h0);
    reset_dut;
    wr(OFS_CONTROL, 32'h3);
    evt(KIND_SECOND_OWN, 1'b1);
    rd(OFS_STATUS_ONE);
    chk(rdv & 32'h2, 32'h2);
    evt(KIND_FIRST_OWN, 1'b1);
    rd(OFS_STATUS_TWO);
    chk(rdv, 32'hA504);
    rd(OFS_STATUS_ONE);
    chk(rdv & 32'h2, 32'h0);
    evt(KIND_FIRST_OWN, 1'b0);
    rd(OFS_STATUS_ONE);
    chk(rdv & 32'h2, 32'h0);
    evt(KIND_MASTER_10BIT_HEAD, 1'b1);
    rd(OFS_STATUS_ONE);
    chk(rdv & 32'h2, 32'h0);
    evt(KIND_MASTER_10BIT_TAIL, 1'b1);
    rd(OFS_STATUS_ONE);
    chk(rdv & 32'h2, 32'h2);
    for (n = 0; n < 6; n++)
    begin
      if (n == 3) wr(OFS_CONTROL, 32'h1F);
      evt(hk[n % 3], 1'b1);
      rd(OFS_STATUS_TWO);
      chk(rdv & hm[n % 3], (n > 2) ? hm[n % 3] : 32'h0);
    end
    @(posedge clk) lost <= 1'b1;
    @(posedge clk) lost <= 1'b0;
    rd(OFS_STATUS_TWO);
    chk(rdv & 32'h4, 32'h0);
    evt(KIND_SECOND_OWN, 1'b1);
    wr(OFS_CONTROL, 32'h0);
    rd(OFS_STATUS_ONE);
    chk(rdv & 32'h2, 32'h0);
    rd(OFS_STATUS_TWO);
    chk(rdv & 32'hF5, 32'h0);
    print_verdict;
  end
endmodule : tb
`default_nettype wire
